// *** host_model.sv ***
// host controller model that issues commands on the command port
`timescale 1ns/1ps
module host_model (
    input  wire logic        clock_i,
    input  wire logic        rsp_valid_i,
    input  wire logic [7:0]  rsp_status_i,
    input  wire logic [31:0] rsp_data_i,
    output logic             cmd_valid_o,
    output logic      [3:0]  cmd_op_o,
    output logic      [7:0]  cmd_mode_o,
    output logic      [3:0]  cmd_slot_o,
    output logic      [31:0] cmd_data_o
);
    // ==========================================================
    // command issue
    // callers write and slot-lock parent, boot and protection keys
    // before they rely on them
    initial begin
        cmd_valid_o = 1'b0;
        cmd_op_o    = 4'h0;
        cmd_mode_o  = 8'h00;
        cmd_slot_o  = 4'h0;
        cmd_data_o  = 32'h0;
    end
    task automatic send(input logic [3:0] op, input logic [7:0] md,
        input logic [3:0] sl, input logic [31:0] d,
        output logic [7:0] st, output logic [31:0] rd, output bit ok);
        int n;
        n  = 0;
        ok = 1'b0;
        @(posedge clock_i);
        #1;
        {cmd_op_o, cmd_mode_o, cmd_slot_o, cmd_data_o} = {op, md, sl, d};
        cmd_valid_o = 1'b1;
        while (!ok && n < 8) begin
            @(posedge clock_i);
            #1;
            n++;
            ok = (rsp_valid_i === 1'b1);
        end
        st = rsp_status_i;
        rd = rsp_data_i;
        // drop before the idle edge, else the command is taken twice
        cmd_valid_o = 1'b0;
        cmd_data_o  = ~d;
    endtask : send
endmodule : host_model

// *** key_slot_access_policy.sv ***
// file: access policy enforcement for the data-zone slots
`timescale 1ns/1ps
module key_slot_access_policy (
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [3:0]  cmd_op_i,
    input  wire logic [7:0]  cmd_mode_i,
    input  wire logic [3:0]  cmd_slot_i,
    input  wire logic [31:0] cmd_data_i,
    input  wire logic        cfg_we_i,
    input  wire logic [3:0]  cfg_slot_i,
    input  wire logic [15:0] cfg_policy_i,
    input  wire logic [31:0] entropy_i,
    input  wire logic        verify_ok_i,
    output logic             rsp_valid_o,
    output logic      [7:0]  rsp_status_o,
    output logic      [31:0] rsp_data_o,
    output logic      [15:0] slot_locked_flags_o
);
    // ==========================================================
    // state
    slot_policy_pkg::fsm_t state_reg, state_next;
    logic [15:0] policy_reg [16];
    logic [15:0] policy_next [16];
    logic [15:0] locked_reg, locked_next;
    logic [15:0] valid_reg, valid_next;
    logic [7:0]  spare_reg, spare_next;
    logic        spare_done_reg, spare_done_next;
    logic [20:0] cnt_reg [2];
    logic [20:0] cnt_next [2];
    logic        boot_ok_reg, boot_ok_next;
    logic        rsp_valid_reg, rsp_valid_next;
    logic [7:0]  status_reg, status_next;
    logic [31:0] data_reg, data_next;
    logic [3:0]  op_reg, op_next;
    logic [7:0]  mode_reg, mode_next;
    logic [3:0]  slot_reg, slot_next;
    logic [31:0] wdata_reg, wdata_next;
    logic        mem_we;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;
    logic [15:0] pol;
    logic        locked_now;
    logic        frozen;
    logic        usable;

    slot_data_mem u_mem (
        .clock_i (clock_i),
        .we_i    (mem_we),
        .addr_i  (slot_reg),
        .wdata_i (mem_wdata),
        .rdata_o (mem_rdata)
    );

    // ==========================================================
    // policy decode for the slot in service
    always_comb begin
        pol        = policy_reg[slot_reg];
        locked_now = ~locked_reg[slot_reg];
        frozen     = pol[slot_policy_pkg::POL_PERM] | locked_now;
        // boot gating only applies where the slot asks for it
        usable     = ~(pol[slot_policy_pkg::POL_BOOTREQ] & ~boot_ok_reg)
                   & ~(pol[slot_policy_pkg::POL_VALIDATE]
                       & ~valid_reg[slot_reg]);
    end

    // ==========================================================
    // command engine
    always_comb begin
        state_next      = state_reg;
        policy_next     = policy_reg;
        locked_next     = locked_reg;
        valid_next      = valid_reg;
        spare_next      = spare_reg;
        spare_done_next = spare_done_reg;
        cnt_next        = cnt_reg;
        boot_ok_next    = boot_ok_reg;
        rsp_valid_next  = 1'b0;
        status_next     = status_reg;
        data_next       = data_reg;
        op_next         = op_reg;
        mode_next       = mode_reg;
        slot_next       = slot_reg;
        wdata_next      = wdata_reg;
        mem_we          = 1'b0;
        mem_wdata       = wdata_reg;
        if (cfg_we_i) begin
            policy_next[cfg_slot_i] = cfg_policy_i;
        end
        case (state_reg)
            slot_policy_pkg::ST_IDLE: begin
                if (cmd_valid_i) begin
                    op_next    = cmd_op_i;
                    mode_next  = cmd_mode_i;
                    slot_next  = cmd_slot_i;
                    wdata_next = cmd_data_i;
                    state_next = slot_policy_pkg::ST_FETCH;
                end
            end
            // one cycle for the registered memory read
            slot_policy_pkg::ST_FETCH: begin
                state_next = slot_policy_pkg::ST_EXEC;
            end
            slot_policy_pkg::ST_EXEC: begin
                state_next     = slot_policy_pkg::ST_IDLE;
                rsp_valid_next = 1'b1;
                status_next    = slot_policy_pkg::ST_REFUSE;
                data_next      = 32'h0000_0000;
                case (op_reg)
                    slot_policy_pkg::CMD_READ: begin
                        if (!pol[slot_policy_pkg::POL_PRIVATE]
                            && pol[slot_policy_pkg::POL_CLR_READ]) begin
                            status_next = slot_policy_pkg::ST_OK;
                            data_next   = mem_rdata;
                        end
                    end
                    slot_policy_pkg::CMD_WRITE: begin
                        // private slots take no outside value
                        if (!frozen && !pol[slot_policy_pkg::POL_PRIVATE]
                            && !(pol[slot_policy_pkg::POL_VALIDATE]
                                 && valid_reg[slot_reg])) begin
                            mem_we      = 1'b1;
                            status_next = slot_policy_pkg::ST_OK;
                        end
                    end
                    slot_policy_pkg::CMD_KEYGEN: begin
                        if (mode_reg == slot_policy_pkg::KEYGEN_REGEN) begin
                            if (pol[slot_policy_pkg::POL_PRIVATE]
                                && !frozen) begin
                                mem_we      = 1'b1;
                                mem_wdata   = entropy_i;
                                status_next = slot_policy_pkg::ST_OK;
                            end
                        end else if (mode_reg
                                     == slot_policy_pkg::KEYGEN_PUBLIC) begin
                            if (pol[slot_policy_pkg::POL_PRIVATE]
                                && usable) begin
                                status_next = slot_policy_pkg::ST_OK;
                                data_next   = ~mem_rdata;
                            end
                        end else begin
                            status_next = slot_policy_pkg::ST_BADCMD;
                        end
                    end
                    slot_policy_pkg::CMD_LOCK: begin
                        if (mode_reg == slot_policy_pkg::LOCK_SINGLE
                            && !pol[slot_policy_pkg::POL_LOCK_N]
                            && !frozen) begin
                            locked_next[slot_reg] = 1'b0;
                            status_next = slot_policy_pkg::ST_OK;
                        end
                    end
                    slot_policy_pkg::CMD_SIGN: begin
                        if (usable && pol[slot_policy_pkg::POL_PRIVATE]
                            && (pol[slot_policy_pkg::POL_EXT_SIGN]
                                || (pol[slot_policy_pkg::POL_INT_SIGN]
                                    && mode_reg
                                    == slot_policy_pkg::SIGN_INTERNAL))) begin
                            status_next = slot_policy_pkg::ST_OK;
                            data_next   = mem_rdata ^ wdata_reg;
                        end
                    end
                    slot_policy_pkg::CMD_ECDH: begin
                        if (usable && pol[slot_policy_pkg::POL_ECDH]) begin
                            status_next = slot_policy_pkg::ST_OK;
                            data_next   = mem_rdata ^ wdata_reg;
                        end
                    end
                    slot_policy_pkg::CMD_VERIFY: begin
                        if (pol[slot_policy_pkg::POL_VALIDATE]
                            && verify_ok_i) begin
                            if (mode_reg == slot_policy_pkg::VERIFY_VALID) begin
                                valid_next[slot_reg] = 1'b1;
                                status_next = slot_policy_pkg::ST_OK;
                            end else if (mode_reg
                                         == slot_policy_pkg::VERIFY_INVAL) begin
                                valid_next[slot_reg] = 1'b0;
                                status_next = slot_policy_pkg::ST_OK;
                            end
                        end
                    end
                    slot_policy_pkg::CMD_BOOTCHK: begin
                        boot_ok_next = verify_ok_i;
                        if (verify_ok_i) begin
                            status_next = slot_policy_pkg::ST_OK;
                        end
                    end
                    slot_policy_pkg::CMD_COUNTER: begin
                        status_next = slot_policy_pkg::ST_OK;
                        if (mode_reg == slot_policy_pkg::COUNTER_INC) begin
                            if (cnt_reg[slot_reg[0]]
                                == slot_policy_pkg::COUNTER_MAX) begin
                                status_next = slot_policy_pkg::ST_REFUSE;
                            end else begin
                                cnt_next[slot_reg[0]] =
                                    cnt_reg[slot_reg[0]] + 21'h000001;
                            end
                        end
                        data_next = {11'h000, cnt_next[slot_reg[0]]};
                    end
                    slot_policy_pkg::CMD_EXTRA: begin
                        if (!spare_done_reg) begin
                            spare_next      = wdata_reg[7:0];
                            spare_done_next = 1'b1;
                            status_next     = slot_policy_pkg::ST_OK;
                        end
                    end
                    slot_policy_pkg::CMD_CFGREAD: begin
                        status_next = slot_policy_pkg::ST_OK;
                        if (wdata_reg[7:0]
                            == slot_policy_pkg::USER_SPARE_BYTE_OFS) begin
                            data_next = {24'h000000, spare_reg};
                        end else if (wdata_reg[7:0]
                                     == slot_policy_pkg::LOCKED_LO_OFS) begin
                            data_next = {24'h000000, locked_reg[7:0]};
                        end else if (wdata_reg[7:0]
                                     == slot_policy_pkg::LOCKED_HI_OFS) begin
                            data_next = {24'h000000, locked_reg[15:8]};
                        end else begin
                            status_next = slot_policy_pkg::ST_BADCMD;
                        end
                    end
                    default: begin
                        status_next = slot_policy_pkg::ST_BADCMD;
                    end
                endcase
            end
            default: begin
                state_next = slot_policy_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_reg      <= slot_policy_pkg::ST_IDLE;
            for (int i = 0; i < 16; i++) begin
                policy_reg[i] <= slot_policy_pkg::POLICY_RESET;
            end
            locked_reg     <= slot_policy_pkg::LOCKED_RESET;
            valid_reg      <= 16'h0000;
            spare_reg      <= slot_policy_pkg::SPARE_RESET;
            spare_done_reg <= 1'b0;
            cnt_reg[0]     <= 21'h000000;
            cnt_reg[1]     <= 21'h000000;
            boot_ok_reg    <= 1'b0;
            rsp_valid_reg  <= 1'b0;
            status_reg     <= slot_policy_pkg::ST_OK;
            data_reg       <= 32'h0000_0000;
            op_reg         <= 4'h0;
            mode_reg       <= 8'h00;
            slot_reg       <= 4'h0;
            wdata_reg      <= 32'h0000_0000;
        end else begin
            state_reg      <= state_next;
            policy_reg     <= policy_next;
            locked_reg     <= locked_next;
            valid_reg      <= valid_next;
            spare_reg      <= spare_next;
            spare_done_reg <= spare_done_next;
            cnt_reg        <= cnt_next;
            boot_ok_reg    <= boot_ok_next;
            rsp_valid_reg  <= rsp_valid_next;
            status_reg     <= status_next;
            data_reg       <= data_next;
            op_reg         <= op_next;
            mode_reg       <= mode_next;
            slot_reg       <= slot_next;
            wdata_reg      <= wdata_next;
        end
    end

    assign rsp_valid_o         = rsp_valid_reg;
    assign rsp_status_o        = status_reg;
    assign rsp_data_o          = data_reg;
    assign slot_locked_flags_o = locked_reg;

    // ==========================================================
    // checks
    a_lock_clears: assert property (@(posedge clock_i)
        disable iff (srst_i) state_reg == slot_policy_pkg::ST_EXEC
        && op_reg == slot_policy_pkg::CMD_LOCK && !frozen
        && mode_reg == slot_policy_pkg::LOCK_SINGLE
        && !pol[slot_policy_pkg::POL_LOCK_N]
        |=> !locked_reg[$past(slot_reg)])
        else $error("slot lock left its flag set");
    a_locked_oneway: assert property (@(posedge clock_i)
        disable iff (srst_i) |(locked_reg & ~$past(locked_reg)) == 1'b0)
        else $error("locked flag set back to one");
    a_spare_once: assert property (@(posedge clock_i)
        disable iff (srst_i) $past(spare_done_reg) |-> $stable(spare_reg))
        else $error("spare byte changed twice");
    a_cnt_bound: assert property (@(posedge clock_i)
        disable iff (srst_i) cnt_reg[0] <= slot_policy_pkg::COUNTER_MAX
        && cnt_reg[1] <= slot_policy_pkg::COUNTER_MAX)
        else $error("counter over maximum");
    a_cnt_mono: assert property (@(posedge clock_i)
        disable iff (srst_i) cnt_reg[0] >= $past(cnt_reg[0])
        && cnt_reg[1] >= $past(cnt_reg[1]))
        else $error("counter went down");
    a_no_priv_read: assert property (@(posedge clock_i)
        disable iff (srst_i) state_reg == slot_policy_pkg::ST_EXEC && op_reg
        == slot_policy_pkg::CMD_READ && pol[slot_policy_pkg::POL_PRIVATE]
        |=> rsp_valid_o && rsp_status_o == slot_policy_pkg::ST_REFUSE
        && rsp_data_o == 32'h0000_0000)
        else $error("private slot read out");
    a_frozen_nowrite: assert property (@(posedge clock_i)
        disable iff (srst_i)
        state_reg == slot_policy_pkg::ST_EXEC && frozen |-> !mem_we)
        else $error("write to frozen slot");
    a_regen_entropy: assert property (@(posedge clock_i)
        disable iff (srst_i)
        mem_we && pol[slot_policy_pkg::POL_PRIVATE]
        |-> mem_wdata == entropy_i)
        else $error("private key from outside");
    a_rsp_timing: assert property (@(posedge clock_i)
        disable iff (srst_i) state_reg == slot_policy_pkg::ST_IDLE
        && cmd_valid_i |-> ##3 rsp_valid_o)
        else $error("response not three cycles after command");
    a_boot_gate: assert property (@(posedge clock_i)
        disable iff (srst_i) state_reg == slot_policy_pkg::ST_EXEC && op_reg
        == slot_policy_pkg::CMD_SIGN && pol[slot_policy_pkg::POL_BOOTREQ]
        && !boot_ok_reg |=> rsp_status_o == slot_policy_pkg::ST_REFUSE)
        else $error("signed without boot check");
    a_int_sign: assert property (@(posedge clock_i)
        disable iff (srst_i) state_reg == slot_policy_pkg::ST_EXEC && op_reg
        == slot_policy_pkg::CMD_SIGN && !pol[slot_policy_pkg::POL_EXT_SIGN]
        && mode_reg != slot_policy_pkg::SIGN_INTERNAL
        |=> rsp_status_o == slot_policy_pkg::ST_REFUSE)
        else $error("internal key signed outside message");
    c_lock: cover property (@(posedge clock_i) $fell(locked_reg[2]));
    c_regen: cover property (@(posedge clock_i) mem_we
        && op_reg == slot_policy_pkg::CMD_KEYGEN);
    c_spare: cover property (@(posedge clock_i) $rose(spare_done_reg));
endmodule : key_slot_access_policy

// *** key_slot_access_policy_bench.sv ***
// self-checking bench for the key slot access policy block
`timescale 1ns/1ps
module key_slot_access_policy_bench;
    logic        clock_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        cfg_we_i = 1'b0;
    logic [3:0]  cfg_slot_i = 4'h0;
    logic [15:0] cfg_policy_i = 16'h0000;
    logic [31:0] entropy_i = 32'h3c5a9671;
    logic        verify_ok_i = 1'b0;
    logic        cmd_valid, rsp_valid;
    logic [3:0]  cmd_op, cmd_slot;
    logic [7:0]  cmd_mode, rsp_status;
    logic [31:0] cmd_data, rsp_data;
    logic [15:0] flags;
    int          num_errors = 0;
    int          total_checks = 0;
    always #50 clock_i = ~clock_i;
    key_slot_access_policy i_key_slot_access_policy (.clock_i(clock_i),
        .srst_i(srst_i), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
        .cmd_mode_i(cmd_mode), .cmd_slot_i(cmd_slot),
        .cmd_data_i(cmd_data), .cfg_we_i(cfg_we_i), .cfg_slot_i(cfg_slot_i),
        .cfg_policy_i(cfg_policy_i), .entropy_i(entropy_i),
        .verify_ok_i(verify_ok_i), .rsp_valid_o(rsp_valid),
        .rsp_status_o(rsp_status), .rsp_data_o(rsp_data),
        .slot_locked_flags_o(flags));
    host_model i_host_model (.clock_i(clock_i), .rsp_valid_i(rsp_valid),
        .rsp_status_i(rsp_status), .rsp_data_i(rsp_data),
        .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op), .cmd_mode_o(cmd_mode),
        .cmd_slot_o(cmd_slot), .cmd_data_o(cmd_data));
    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic prov(input logic [3:0] sl, input logic [15:0] pol);
        @(posedge clock_i);
        #1;
        {cfg_we_i, cfg_slot_i, cfg_policy_i} = {1'b1, sl, pol};
        @(posedge clock_i);
        #1;
        cfg_we_i = 1'b0;
    endtask : prov
    // r: 0 ok, 1 refused, 2 bad command; m masks data we cannot predict
    task automatic run(input logic [3:0] op, input logic [7:0] md,
        input logic [3:0] sl, input logic [31:0] d, input int r,
        input logic [31:0] ed, input logic [31:0] m);
        logic [7:0]  st;
        logic [31:0] rd;
        bit          ok;
        i_host_model.send(op, md, sl, d, st, rd, ok);
        chk({31'h0, ok}, 32'h1, "no response");
        chk({24'h0, st}, {24'h0, r == 2 ? slot_policy_pkg::ST_BADCMD :
            r == 1 ? slot_policy_pkg::ST_REFUSE : slot_policy_pkg::ST_OK},
            "status");
        chk(rd & m, ed, "data");
    endtask : run
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    // ==========================================================
    // watchdog, far beyond fifty commands of four cycles
    initial begin
        #600000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict;
    end
    // ==========================================================
    // scenarios
    initial begin
        repeat (3) @(posedge clock_i);
        #1 srst_i = 1'b0;
        chk({16'h0, flags}, 32'hffff, "flags reset");
        run(slot_policy_pkg::CMD_CFGREAD, 8'h0, 0, 32'h59, 0, 32'hff, 32'hff);
        prov(4'h0, 16'h009b);
        prov(4'h1, 16'h0015);
        prov(4'h2, 16'h000b);
        prov(4'h5, 16'h0140);
        prov(4'ha, 16'h0100);
        run(slot_policy_pkg::CMD_READ, 8'h0, 4'h0, 0, 1, 0, '1);
        run(slot_policy_pkg::CMD_KEYGEN, 8'h04, 4'h2, 0, 0, 0, 0);
        run(slot_policy_pkg::CMD_READ, 8'h0, 4'h2, 0, 1, 0, '1);
        run(slot_policy_pkg::CMD_KEYGEN, 8'h00, 4'h2, 0, 0, ~entropy_i, '1);
        run(slot_policy_pkg::CMD_KEYGEN, 8'h01, 4'h2, 0, 2, 0, '1);
        run(slot_policy_pkg::CMD_KEYGEN, 8'h04, 4'h0, 0, 1, 0, '1);
        run(slot_policy_pkg::CMD_KEYGEN, 8'h00, 4'h0, 0, 1, 0, '1);
        run(slot_policy_pkg::CMD_SIGN, 8'h00, 4'h1, 5, 1, 0, '1);
        run(slot_policy_pkg::CMD_SIGN, 8'h80, 4'h1, 5, 0, 0, 0);
        run(slot_policy_pkg::CMD_SIGN, 8'h00, 4'h0, 5, 1, 0, '1);
        prov(4'hf, 16'h0100);
        run(slot_policy_pkg::CMD_WRITE, 8'h0, 4'hf, 32'hb00f, 0, 0, 0);
        run(slot_policy_pkg::CMD_LOCK, 8'h02, 4'hf, 0, 0, 0, 0);
        verify_ok_i = 1'b1;
        run(slot_policy_pkg::CMD_BOOTCHK, 8'h00, 4'h0, 0, 0, 0, 0);
        run(slot_policy_pkg::CMD_KEYGEN, 8'h00, 4'h0, 0, 0, 0, 0);
        run(slot_policy_pkg::CMD_SIGN, 8'h00, 4'h0, 5, 0, 0, 0);
        prov(4'h6, 16'h0100);
        run(slot_policy_pkg::CMD_WRITE, 8'h0, 4'h6, 32'h10c0, 0, 0, 0);
        run(slot_policy_pkg::CMD_LOCK, 8'h02, 4'h6, 0, 0, 0, 0);
        run(slot_policy_pkg::CMD_ECDH, 8'h00, 4'h0, 5, 0, 0, 0);
        run(slot_policy_pkg::CMD_SIGN, 8'h0, 4'h2, 7, 0, entropy_i ^ 7, '1);
        run(slot_policy_pkg::CMD_LOCK, 8'h02, 4'h2, 0, 0, 0, 0);
        run(slot_policy_pkg::CMD_KEYGEN, 8'h04, 4'h2, 0, 1, 0, '1);
        run(slot_policy_pkg::CMD_LOCK, 8'h02, 4'h2, 0, 1, 0, '1);
        run(slot_policy_pkg::CMD_WRITE, 8'h0, 4'ha, 32'hc3e10a5b, 0, 0, 0);
        run(slot_policy_pkg::CMD_LOCK, 8'h02, 4'ha, 0, 0, 0, 0);
        run(slot_policy_pkg::CMD_WRITE, 8'h0, 4'ha, 32'h1, 1, 0, '1);
        run(slot_policy_pkg::CMD_READ, 8'h0, 4'ha, 0, 0, 32'hc3e10a5b, '1);
        chk({16'h0, flags}, 32'h7bbb, "flags locked");
        run(slot_policy_pkg::CMD_CFGREAD, 8'h0, 0, 32'h58, 0, 32'hbb, 32'hff);
        run(slot_policy_pkg::CMD_CFGREAD, 8'h0, 0, 32'h59, 0, 32'h7b, 32'hff);
        prov(4'h4, 16'h0100);
        run(slot_policy_pkg::CMD_WRITE, 8'h0, 4'h4, 32'h9a7e, 0, 0, 0);
        run(slot_policy_pkg::CMD_LOCK, 8'h02, 4'h4, 0, 0, 0, 0);
        run(slot_policy_pkg::CMD_WRITE, 8'h0, 4'h5, 32'h11, 0, 0, 0);
        run(slot_policy_pkg::CMD_VERIFY, 8'h01, 4'h5, 0, 0, 0, 0);
        run(slot_policy_pkg::CMD_WRITE, 8'h0, 4'h5, 32'h22, 1, 0, '1);
        run(slot_policy_pkg::CMD_VERIFY, 8'h02, 4'h5, 0, 0, 0, 0);
        run(slot_policy_pkg::CMD_WRITE, 8'h0, 4'h5, 32'h22, 0, 0, 0);
        run(slot_policy_pkg::CMD_COUNTER, 8'h01, 4'h0, 0, 0, 1, '1);
        run(slot_policy_pkg::CMD_COUNTER, 8'h01, 4'h0, 0, 0, 2, '1);
        run(slot_policy_pkg::CMD_COUNTER, 8'h00, 4'h1, 0, 0, 0, '1);
        run(slot_policy_pkg::CMD_EXTRA, 8'h0, 4'h0, 32'h5a, 0, 0, 0);
        run(slot_policy_pkg::CMD_EXTRA, 8'h0, 4'h0, 32'ha5, 1, 0, '1);
        run(slot_policy_pkg::CMD_CFGREAD, 8'h0, 0, 32'h54, 0, 32'h5a, 32'hff);
        give_verdict;
    end
endmodule : key_slot_access_policy_bench

// *** slot_data_mem.sv ***
// file: slot data memory, 16 slots of 32 bits, registered read
`timescale 1ns/1ps
module slot_data_mem (
    input  wire logic        clock_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    output logic      [31:0] rdata_o
);
    logic [31:0] mem_reg [16];
    logic [31:0] rdata_reg;

    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem_reg[addr_i] <= wdata_i;
        end
        rdata_reg <= mem_reg[addr_i];
    end

    assign rdata_o = rdata_reg;
endmodule : slot_data_mem

// *** slot_policy_pkg.sv ***
// package: constants and types for the key slot access policy block
package slot_policy_pkg;

    // ==========================================================
    // configuration byte positions
    localparam logic [7:0] USER_SPARE_BYTE_OFS = 8'h54;
    localparam logic [7:0] LOCKED_LO_OFS       = 8'h58;
    localparam logic [7:0] LOCKED_HI_OFS       = 8'h59;

    // ==========================================================
    // slot numbers
    localparam logic [3:0] SLOT_PRIMARY    = 4'h0;
    localparam logic [3:0] SLOT_INT_SIGN   = 4'h1;
    localparam logic [3:0] SLOT_DEV_CERT   = 4'ha;
    localparam logic [3:0] SLOT_SIGNER_PUB = 4'hb;
    localparam logic [3:0] SLOT_SIGNER_CRT = 4'hc;

    // ==========================================================
    // command codes on the command port
    localparam logic [3:0] CMD_READ     = 4'h1;
    localparam logic [3:0] CMD_WRITE    = 4'h2;
    localparam logic [3:0] CMD_KEYGEN   = 4'h3;
    localparam logic [3:0] CMD_LOCK     = 4'h4;
    localparam logic [3:0] CMD_SIGN     = 4'h5;
    localparam logic [3:0] CMD_ECDH     = 4'h6;
    localparam logic [3:0] CMD_VERIFY   = 4'h7;
    localparam logic [3:0] CMD_COUNTER  = 4'h8;
    localparam logic [3:0] CMD_EXTRA    = 4'h9;
    localparam logic [3:0] CMD_BOOTCHK  = 4'ha;
    localparam logic [3:0] CMD_CFGREAD  = 4'hb;

    // ==========================================================
    // mode values
    localparam logic [7:0] KEYGEN_PUBLIC = 8'h00;
    localparam logic [7:0] KEYGEN_REGEN  = 8'h04;
    localparam logic [7:0] LOCK_SINGLE   = 8'h02;
    localparam logic [7:0] VERIFY_VALID  = 8'h01;
    localparam logic [7:0] VERIFY_INVAL  = 8'h02;
    localparam logic [7:0] COUNTER_INC   = 8'h01;
    localparam logic [7:0] SIGN_INTERNAL = 8'h80;

    // ==========================================================
    // counters and reset values
    localparam logic [20:0] COUNTER_MAX    = 21'h1fffff;
    localparam logic [15:0] LOCKED_RESET   = 16'hffff;
    localparam logic [7:0]  SPARE_RESET    = 8'h00;
    localparam logic [15:0] POLICY_RESET   = 16'h0000;

    // ==========================================================
    // status codes
    localparam logic [7:0] ST_OK     = 8'h00;
    localparam logic [7:0] ST_REFUSE = 8'h01;
    localparam logic [7:0] ST_BADCMD = 8'h03;

    // policy word layout per slot, two configuration bytes
    localparam int POL_PRIVATE  = 0;
    localparam int POL_EXT_SIGN = 1;
    localparam int POL_INT_SIGN = 2;
    localparam int POL_ECDH     = 3;
    localparam int POL_PERM     = 4;
    localparam int POL_LOCK_N   = 5;
    localparam int POL_VALIDATE = 6;
    localparam int POL_BOOTREQ  = 7;
    localparam int POL_CLR_READ = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_EXEC = 3'b100
    } fsm_t;

endpackage : slot_policy_pkg
